// *** core/low_power_mode_sequencer.sv ***
// Notes on behaviour
// - Sleep stops core clock, keeps PLL and system clock running.
// - Sleep wake samples bypass select; not bypassed goes full-on.
// - Sleep wake with bypass selected goes to active.
// - No system DMA to level-one memory while asleep.
// - Deep sleep stops core clock and system clock.
// - Deep sleep blocks asynchronous peripherals from internal and external memory.
// - Deep sleep exits only on reset or RTC interrupt.
// - RTC interrupt in deep sleep moves to active.
// - Reset input in deep sleep moves to full-on.
// - Writing zero regulator frequency code enters hibernate, regulator off.
// - Hibernate stops both clocks and drives core supply to zero.
// - Hibernate puts external pins in high impedance.
// - Regulator restarts from hibernate only on RTC wake or reset pin.
// - Active mode bypasses PLL; both clocks run at input clock rate.
// - Disabled PLL must be re-enabled before full-on or sleep; only requests check pll_enable, wakes enter full-on without it.
`timescale 1ns/10ps
module low_power_mode_sequencer
	import pwr_seq_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              req_valid,
	input  wire pwr_req_t          req_mode,
	output logic                   req_ready,
	input  wire logic              reg_wr,
	input  wire logic [REGULATOR_FIELD_A_W-1:0] reg_regulator_field_a,
	input  wire logic              pll_bypass_sel,
	input  wire logic              pll_enable,
	input  wire logic [DIV_CNT_W-1:0] sys_div,
	input  wire logic              wake_event,
	input  wire logic              rtc_wake_async,
	input  wire logic              reset_pin_async,
	input  wire logic              dma_l1_req,
	output logic                   dma_l1_grant,
	input  wire logic              async_periph_req,
	output logic                   async_periph_grant,
	output logic                   core_clk_en,
	output logic                   system_clk_en,
	output logic                   pll_bypassed,
	output logic                   regulator_on,
	output logic                   core_supply_on,
	output logic                   pins_hiz,
	output logic [REGULATOR_FIELD_A_W-1:0]      regulator_field_a,
	output pwr_mode_t              mode
);
	clk_ctl_if cc ();

	logic      rtc_wake;
	logic      reset_wake;
	pwr_mode_t mode_q;
	pwr_mode_t mode_d;
	logic [REGULATOR_FIELD_A_W-1:0] regulator_field_a_q;
	logic [REGULATOR_FIELD_A_W-1:0] regulator_field_a_d;
	logic      grant_q;
	logic      grant_d;
	logic      agrant_q;
	logic      agrant_d;
	logic      hiz_q;
	logic      hiz_d;

	// Only the synchronised copies are used; raw pins never touch the FSM
	wake_sync u_rtc_sync (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.async_in (rtc_wake_async),
		.sync_out (rtc_wake)
	);

	wake_sync u_rst_sync (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.async_in (reset_pin_async),
		.sync_out (reset_wake)
	);

	clk_gate_gen u_gate (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.sys_div (sys_div),
		.cc      (cc.gate)
	);

	always_comb begin
		mode_d = mode_q;
		regulator_field_a_d = regulator_field_a_q;
		if (reg_wr && mode_q != MODE_HIBERNATE)
			regulator_field_a_d = reg_regulator_field_a;
		case (mode_q)
			MODE_FULL_ON, MODE_ACTIVE: begin
				if (reg_wr && reg_regulator_field_a == REGULATOR_FIELD_A_OFF) begin
					mode_d = MODE_HIBERNATE;
				end else if (req_valid) begin
					case (req_mode)
						REQ_SLEEP: begin
							if (pll_enable)
								mode_d = MODE_SLEEP;
						end
						REQ_FULL_ON: begin
							if (pll_enable && !pll_bypass_sel)
								mode_d = MODE_FULL_ON;
						end
						REQ_ACTIVE:     mode_d = MODE_ACTIVE;
						REQ_DEEP_SLEEP: mode_d = MODE_DEEP_SLEEP;
						default:        mode_d = mode_q;
					endcase
				end
			end
			MODE_SLEEP: begin
				if (wake_event || rtc_wake || reset_wake)
					mode_d = pll_bypass_sel ? MODE_ACTIVE : MODE_FULL_ON;
			end
			MODE_DEEP_SLEEP: begin
				// Reset wins if both arrive together
				if (reset_wake)
					mode_d = MODE_FULL_ON;
				else if (rtc_wake)
					mode_d = MODE_ACTIVE;
			end
			MODE_HIBERNATE: begin
				// Core state is lost, so the regulator field returns to its reset code
				if (reset_wake) begin
					mode_d = MODE_FULL_ON;
					regulator_field_a_d = REGULATOR_FIELD_A_RESET;
				end else if (rtc_wake) begin
					mode_d = MODE_ACTIVE;
					regulator_field_a_d = REGULATOR_FIELD_A_RESET;
				end
			end
			default: mode_d = MODE_FULL_ON;
		endcase
		grant_d  = dma_l1_req && mode_d != MODE_SLEEP && mode_d != MODE_DEEP_SLEEP
			&& mode_d != MODE_HIBERNATE;
		agrant_d = async_periph_req && (mode_d == MODE_FULL_ON || mode_d == MODE_ACTIVE);
		hiz_d    = (mode_d == MODE_HIBERNATE);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mode_q   <= MODE_FULL_ON;
			regulator_field_a_q   <= REGULATOR_FIELD_A_RESET;
			grant_q  <= 1'b0;
			agrant_q <= 1'b0;
			hiz_q    <= 1'b0;
		end else begin
			mode_q   <= mode_d;
			regulator_field_a_q   <= regulator_field_a_d;
			grant_q  <= grant_d;
			agrant_q <= agrant_d;
			hiz_q    <= hiz_d;
		end
	end

	always_comb begin
		cc.core_en = (mode_q == MODE_FULL_ON || mode_q == MODE_ACTIVE);
		cc.sys_en  = (mode_q == MODE_FULL_ON || mode_q == MODE_ACTIVE
			|| mode_q == MODE_SLEEP);
		cc.bypass  = (mode_q == MODE_ACTIVE);
	end

	assign req_ready          = (mode_q == MODE_FULL_ON || mode_q == MODE_ACTIVE);
	assign core_clk_en        = cc.core_gate;
	assign system_clk_en      = cc.sys_gate;
	assign pll_bypassed       = cc.bypass;
	assign regulator_on       = (mode_q != MODE_HIBERNATE);
	assign core_supply_on     = (mode_q != MODE_HIBERNATE);
	assign pins_hiz           = hiz_q;
	assign dma_l1_grant       = grant_q;
	assign async_periph_grant = agrant_q;
	assign regulator_field_a  = regulator_field_a_q;
	assign mode               = mode_q;
endmodule : low_power_mode_sequencer

// *** core/pwr_seq_pkg.sv ***
package pwr_seq_pkg;

	typedef enum logic [2:0] {
		MODE_FULL_ON    = 3'b000,
		MODE_ACTIVE     = 3'b001,
		MODE_SLEEP      = 3'b010,
		MODE_DEEP_SLEEP = 3'b011,
		MODE_HIBERNATE  = 3'b100
	} pwr_mode_t;

	// Software requests, one-cycle pulse on req_valid
	typedef enum logic [1:0] {
		REQ_SLEEP      = 2'b00,
		REQ_DEEP_SLEEP = 2'b01,
		REQ_FULL_ON    = 2'b10,
		REQ_ACTIVE     = 2'b11
	} pwr_req_t;

	localparam int          REGULATOR_FIELD_A_W       = 2;
	localparam logic [1:0]  REGULATOR_FIELD_A_OFF     = 2'h0;
	localparam logic [1:0]  REGULATOR_FIELD_A_RESET   = 2'h3;
	localparam logic [1:0]  DIV_W        = 2'h2;
	localparam int          DIV_CNT_W    = 4;
	localparam logic [3:0]  SYS_DIV_RST  = 4'h1;
	localparam logic [2:0]  SYNC_STAGES  = 3'h2;

endpackage : pwr_seq_pkg

// *** core/clk_ctl_if.sv ***
`timescale 1ns/10ps
interface clk_ctl_if;
	logic core_en;
	logic sys_en;
	logic bypass;
	logic core_gate;
	logic sys_gate;

	modport ctl (output core_en, output sys_en, output bypass, input core_gate, input sys_gate);
	modport gate (input core_en, input sys_en, input bypass, output core_gate, output sys_gate);
endinterface : clk_ctl_if

// *** core/wake_sync.sv ***
`timescale 1ns/10ps
module wake_sync (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic async_in,
	output logic      sync_out
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;
endmodule : wake_sync

// *** core/clk_gate_gen.sv ***
`timescale 1ns/10ps
module clk_gate_gen
	import pwr_seq_pkg::*;
(
	input  wire logic  mclk,
	input  wire logic  rst_n,
	input  wire logic  [DIV_CNT_W-1:0] sys_div,
	clk_ctl_if.gate    cc
);
	// Gates are clock-enable strobes sampled on mclk; registered so they never glitch
	logic [DIV_CNT_W-1:0] cnt_q;
	logic [DIV_CNT_W-1:0] cnt_d;
	logic                 core_q;
	logic                 core_d;
	logic                 sys_q;
	logic                 sys_d;
	logic                 tick;

	always_comb begin
		tick  = (cnt_q == '0);
		cnt_d = tick ? sys_div - DIV_CNT_W'(1) : cnt_q - DIV_CNT_W'(1);
		if (sys_div == '0)
			cnt_d = '0;
		core_d = cc.core_en;
		// Bypass runs both clocks at the input clock rate
		sys_d  = cc.sys_en & (cc.bypass | tick | (sys_div == '0));
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cnt_q  <= '0;
			core_q <= 1'b0;
			sys_q  <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			core_q <= core_d;
			sys_q  <= sys_d;
		end
	end

	assign cc.core_gate = core_q;
	assign cc.sys_gate  = sys_q;
endmodule : clk_gate_gen

// *** bench/lpms_props.sv ***
`timescale 1ns/10ps
module lpms_props
	import pwr_seq_pkg::*;
(
	input wire logic		mclk,
	input wire logic		rst_n,
	input wire logic		reg_wr,
	input wire logic [REGULATOR_FIELD_A_W-1:0]	reg_regulator_field_a,
	input wire logic		rtc_wake_async,
	input wire logic		reset_pin_async,
	input wire logic		dma_l1_grant,
	input wire logic		async_periph_grant,
	input wire logic		core_clk_en,
	input wire logic		system_clk_en,
	input wire logic		pll_bypassed,
	input wire logic		regulator_on,
	input wire logic		core_supply_on,
	input wire logic		pins_hiz,
	input wire logic [REGULATOR_FIELD_A_W-1:0]	regulator_field_a,
	input wire pwr_mode_t		mode
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Clock enables lag the mode by one cycle, so only settled cycles are judged
	a_sleep_core_off: assert property ($past(mode) == MODE_SLEEP && mode == MODE_SLEEP |-> !core_clk_en)
		else $error("core clock on in sleep");
	a_sleep_no_dma: assert property (mode == MODE_SLEEP |-> !dma_l1_grant)
		else $error("dma grant in sleep");
	a_deep_clk_off: assert property ($past(mode) == MODE_DEEP_SLEEP && mode == MODE_DEEP_SLEEP
		|-> !core_clk_en && !system_clk_en) else $error("clock on in deep sleep");
	a_deep_no_async: assert property ($past(mode) == MODE_DEEP_SLEEP && mode == MODE_DEEP_SLEEP
		|-> !async_periph_grant) else $error("async grant in deep sleep");
	a_low_hold: assert property ((!rtc_wake_async && !reset_pin_async)[*3] ##0
		(mode == MODE_HIBERNATE || mode == MODE_DEEP_SLEEP && !reg_wr) |=> $stable(mode))
		else $error("left low power without wake");
	a_hib_off: assert property (mode == MODE_HIBERNATE |-> !regulator_on && !core_supply_on && pins_hiz)
		else $error("supply or pins wrong in hibernate");
	// Only a running core can issue the write, so entry is judged from full-on or active alone
	a_enter_hib: assert property (reg_wr && reg_regulator_field_a == REGULATOR_FIELD_A_OFF && (mode == MODE_FULL_ON || mode == MODE_ACTIVE)
		|=> mode == MODE_HIBERNATE && regulator_field_a == REGULATOR_FIELD_A_OFF) else $error("no hibernate entry");
	a_active_clks: assert property ($past(mode) == MODE_ACTIVE && mode == MODE_ACTIVE
		|-> pll_bypassed && core_clk_en && system_clk_en) else $error("active clocks wrong");
	c_sleep_wake: cover property (mode == MODE_SLEEP ##1 mode == MODE_ACTIVE);
	c_deep_reset: cover property (mode == MODE_DEEP_SLEEP ##1 mode == MODE_FULL_ON);
	c_hib_wake: cover property (mode == MODE_HIBERNATE ##1 mode == MODE_ACTIVE);
endmodule : lpms_props

bind low_power_mode_sequencer lpms_props u_props (.*);

// *** bench/wake_src_model.sv ***
`timescale 1ns/10ps
module wake_src_model (
	output logic	rtc_wake_async,
	output logic	reset_pin_async
);
	initial begin
		rtc_wake_async = 1'b0;
		reset_pin_async = 1'b0;
	end
	// Lands 3 ns off the clock edge so the synchroniser sees a truly unaligned input
	task automatic pulse(input logic rtc);
		#3;
		if (rtc) rtc_wake_async = 1'b1;
		else reset_pin_async = 1'b1;
		fork
			#40 {rtc_wake_async, reset_pin_async} = 2'h0;
		join_none
	endtask : pulse
endmodule : wake_src_model

// *** bench/low_power_mode_sequencer_tb_top.sv ***
`timescale 1ns/10ps
module low_power_mode_sequencer_tb_top
	import pwr_seq_pkg::*;
;
	typedef struct {logic v; pwr_req_t r; logic b; logic p; logic w; pwr_mode_t e;} row_t;
	logic			mclk, rst_n, req_valid, reg_wr, pll_bypass_sel, pll_enable, wake_event;
	logic			dma_l1_req, async_periph_req, rtc_wake_async, reset_pin_async, req_ready;
	logic			dma_l1_grant, async_periph_grant, core_clk_en, system_clk_en, pll_bypassed;
	logic			regulator_on, core_supply_on, pins_hiz, ok;
	logic [REGULATOR_FIELD_A_W-1:0]	reg_regulator_field_a, regulator_field_a;
	logic [DIV_CNT_W-1:0]	sys_div;
	pwr_req_t		req_mode;
	pwr_mode_t		mode;
	int			err_count, compares;
	row_t rows [11] = '{'{1, REQ_ACTIVE, 0, 1, 0, MODE_ACTIVE}, '{1, REQ_FULL_ON, 1, 1, 0, MODE_ACTIVE},
		'{1, REQ_SLEEP, 0, 0, 0, MODE_ACTIVE}, '{1, REQ_FULL_ON, 0, 1, 0, MODE_FULL_ON},
		'{1, REQ_SLEEP, 0, 1, 0, MODE_SLEEP}, '{1, REQ_FULL_ON, 0, 1, 0, MODE_SLEEP},
		'{0, REQ_SLEEP, 0, 1, 1, MODE_FULL_ON}, '{1, REQ_SLEEP, 1, 1, 0, MODE_SLEEP},
		'{0, REQ_SLEEP, 1, 1, 1, MODE_ACTIVE}, '{1, REQ_DEEP_SLEEP, 0, 1, 0, MODE_DEEP_SLEEP},
		'{0, REQ_SLEEP, 0, 1, 1, MODE_DEEP_SLEEP}};

	low_power_mode_sequencer dut (.*);
	wake_src_model src (.*);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic chk(input string n, input logic [3:0] s, input logic [3:0] e);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic chk_mode(input pwr_mode_t e);
		chk("mode", {1'b0, mode}, {1'b0, e});
	endtask : chk_mode

	task automatic req(input pwr_req_t r);
		{req_valid, req_mode} = {1'b1, r};
		@(negedge mclk);
		req_valid = 1'b0;
	endtask : req

	task final_report;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report

	initial begin
		{rst_n, req_valid, reg_wr, wake_event, pll_bypass_sel} = 5'h0;
		{pll_enable, dma_l1_req, async_periph_req} = 3'h7;
		req_mode = REQ_SLEEP;
		reg_regulator_field_a = REGULATOR_FIELD_A_RESET;
		sys_div = 4'h2;
		repeat (20) @(negedge mclk);
		chk("reset", {mode, pins_hiz}, {MODE_FULL_ON, 1'b0});
		chk("field", {2'h0, regulator_field_a}, {2'h0, REGULATOR_FIELD_A_RESET});
		rst_n = 1'b1;
		$display("test reset done");
		foreach (rows[i]) begin
			{req_valid, req_mode, pll_bypass_sel, pll_enable, wake_event} = {rows[i].v, rows[i].r, rows[i].b,
				rows[i].p, rows[i].w};
			@(negedge mclk);
			{req_valid, wake_event} = 2'h0;
			repeat (3) @(negedge mclk);
			ok = rows[i].e inside {MODE_FULL_ON, MODE_ACTIVE};
			chk_mode(rows[i].e);
			chk("grants", {1'b0, core_clk_en, dma_l1_grant, async_periph_grant}, {1'b0, {3{ok}}});
			chk("ready", {2'h0, req_ready, pll_bypassed}, {2'h0, ok, rows[i].e == MODE_ACTIVE});
		end
		chk("deepclk", {3'h0, system_clk_en}, 4'h0);
		$display("test rows done");
		src.pulse(1'b1);
		repeat (5) @(negedge mclk);
		chk_mode(MODE_ACTIVE);
		req(REQ_DEEP_SLEEP);
		src.pulse(1'b0);
		repeat (5) @(negedge mclk);
		chk_mode(MODE_FULL_ON);
		$display("test deep sleep done");
		// Bench keeps no state worth saving, so hibernate may be entered at once
		{reg_regulator_field_a, reg_wr} = {REGULATOR_FIELD_A_OFF, 1'b1};
		@(negedge mclk);
		{reg_wr, wake_event} = 2'h1;
		req(REQ_ACTIVE);
		wake_event = 1'b0;
		chk("hib", {regulator_on, core_supply_on, pins_hiz, regulator_field_a != REGULATOR_FIELD_A_OFF}, 4'h2);
		chk_mode(MODE_HIBERNATE);
		chk("hibclk", {2'h0, core_clk_en, system_clk_en}, 4'h0);
		src.pulse(1'b1);
		repeat (2) @(negedge mclk);
		chk_mode(MODE_HIBERNATE);
		repeat (3) @(negedge mclk);
		chk_mode(MODE_ACTIVE);
		chk("actclk", {1'b0, core_clk_en, system_clk_en, pll_bypassed}, 4'h7);
		chk("field", {2'h0, regulator_field_a}, {2'h0, REGULATOR_FIELD_A_RESET});
		$display("test hibernate done");
		rst_n = 1'b0;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		chk_mode(MODE_FULL_ON);
		$display("test mid reset done");
		final_report();
	end

	// Whole sequence needs about 84 cycles; some fourteen times that marks a hang
	initial begin
		#12us;
		err_count++;
		final_report();
	end
endmodule : low_power_mode_sequencer_tb_top
